// ---- pkg/rpr_defs.svh ----
`ifndef RPR_DEFS_SVH
`define RPR_DEFS_SVH
// byte offsets on the register bus
`define RPR_OFS_CAP_ROUTE   8'h00
`define RPR_OFS_FAULT_ROUTE 8'h04
`define RPR_OFS_OUT_28_29   8'h08
`define RPR_OFS_OUT_30_31   8'h0C
`define RPR_OFS_ALT_CLK     8'h10
// field positions inside a route register
`define RPR_HI_LSB          8
`define RPR_LO_LSB          0
`define RPR_ALT_BIT         0
// reset values
`define RPR_IN_SEL_RST      6'h3F
`define RPR_OUT_SEL_RST     6'h00
`define RPR_ALT_RST         1'b0
// codes and sizes
`define RPR_SEL_NULL        6'h00
`define RPR_SCK1_CODE       6'h08
`define RPR_NUM_PINS        6'd46
`endif

// ---- pkg/rpr_pkg.sv ----
package rpr_pkg;
    typedef logic [5:0]  rpr_sel_type;
    typedef logic [15:0] rpr_reg_type;
endpackage

// ---- rtl/rpr_out_mux.sv ----
`include "rpr_defs.svh"
module rpr_out_mux
    import rpr_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire rpr_sel_type sel,
    input  wire logic [63:0] periphOut,
    input  wire logic        altMapOn,
    input  wire logic        portOut,
    input  wire logic        portOe,
    input  wire logic        pmpOut,
    input  wire logic        pmpOe,
    output logic             pinOut,
    output logic             pinOe
);
    logic pinOut_ff;
    logic pinOe_ff;
    logic nxt_pinOut;
    logic nxt_pinOe;
    logic remapOn;

    // the serial clock code is withheld from pins while it rides the fixed pin
    assign remapOn = (sel != `RPR_SEL_NULL) &&
                     !(altMapOn && (sel == `RPR_SCK1_CODE));

    always_comb begin
        if (remapOn) begin
            nxt_pinOut = periphOut[sel];
            nxt_pinOe  = 1'b1;
        end else if (pmpOe) begin
            nxt_pinOut = pmpOut;
            nxt_pinOe  = 1'b1;
        end else begin
            nxt_pinOut = portOut;
            nxt_pinOe  = portOe;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pinOut_ff <= 1'b0;
            pinOe_ff  <= 1'b0;
        end else begin
            pinOut_ff <= nxt_pinOut;
            pinOe_ff  <= nxt_pinOe;
        end
    end

    assign pinOut = pinOut_ff;
    assign pinOe  = pinOe_ff;
endmodule // rpr_out_mux

// ---- rtl/rpr_router.sv ----
// How it works
// - each remappable output pin has its own field choosing the peripheral output.
// - every output route register holds two separate six-bit pin fields.
// - a zero output code leaves the pin free of any remapped peripheral.
// - with the alternate bit set, serial clock one drives only the fixed pin.
// - with the alternate bit clear, serial clock one follows the pin fields.
// - capture route register: channel 8 in bits 13-8, channel 7 in 5-0.
// - fault route register: fault B in bits 13-8, fault A in 5-0.
// - output registers: pin 29 high, 28 low; pin 31 high, 30 low.
// - on smaller packages the pin 31 field is absent and reads zero.
// - unimplemented bits ignore writes and read as zero.
// - an input field value picks the remappable pin of that number.
// - a remapped output beats parallel master port and port output.
// - an analog-enabled pin feeds zero into any remapped input.
`include "rpr_defs.svh"
module rpr_router
    import rpr_pkg::*;
#(
    parameter bit PIN31_PRESENT = 1'b1
)(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [63:0] periphOut,
    input  wire logic [45:0] pinIn,
    input  wire logic [45:0] analogEn,
    input  wire logic [3:0]  portOut,
    input  wire logic [3:0]  portOe,
    input  wire logic [3:0]  pmpOut,
    input  wire logic [3:0]  pmpOe,
    output logic      [3:0]  pinOut,
    output logic      [3:0]  pinOe,
    output logic             altClkOut,
    output logic             altClkOe,
    output logic             capCh7In,
    output logic             capCh8In,
    output logic             faultAIn,
    output logic             faultBIn
);
    // bus state
    logic        wrPend_ff;
    logic [7:0]  wrAddr_ff;
    logic [31:0] hrdata_ff;
    logic        nxt_wrPend;
    logic [7:0]  nxt_wrAddr;
    logic [31:0] nxt_hrdata;
    logic        addrTaken;

    // routing fields
    rpr_sel_type cap7_ff, cap8_ff, fltA_ff, fltB_ff;
    rpr_sel_type out28_ff, out29_ff, out30_ff, out31_ff;
    logic        altMap_ff;
    rpr_sel_type nxt_cap7, nxt_cap8, nxt_fltA, nxt_fltB;
    rpr_sel_type nxt_out28, nxt_out29, nxt_out30, nxt_out31;
    logic        nxt_altMap;

    // pin input synchroniser and routed inputs
    logic [45:0] pinMeta_ff;
    logic [45:0] pinSync_ff;
    logic        cap7In_ff, cap8In_ff, fltAIn_ff, fltBIn_ff;
    logic        altClk_ff;
    logic        nxt_cap7In, nxt_cap8In, nxt_fltAIn, nxt_fltBIn;
    logic        nxt_altClk;
    rpr_sel_type outSel [4];

    function automatic logic pick_pin(input rpr_sel_type sel, input logic [45:0] lvl,
                                      input logic [45:0] ana);
        logic hit;
        hit = 1'b0;
        if (sel < `RPR_NUM_PINS) begin
            hit = lvl[sel] && !ana[sel];
        end
        return hit;
    endfunction

    function automatic rpr_reg_type pack_pair(input rpr_sel_type hi, input rpr_sel_type lo);
        rpr_reg_type r;
        r = 16'h0000;
        r[`RPR_HI_LSB +: 6] = hi;
        r[`RPR_LO_LSB +: 6] = lo;
        return r;
    endfunction

    // zero wait states, so the address phase is taken whenever hready is high
    assign addrTaken = hsel && htrans[1] && hready;

    always_comb begin
        nxt_wrPend = addrTaken && hwrite;
        nxt_wrAddr = addrTaken ? haddr[7:0] : wrAddr_ff;
        nxt_cap7   = cap7_ff;
        nxt_cap8   = cap8_ff;
        nxt_fltA   = fltA_ff;
        nxt_fltB   = fltB_ff;
        nxt_out28  = out28_ff;
        nxt_out29  = out29_ff;
        nxt_out30  = out30_ff;
        nxt_out31  = out31_ff;
        nxt_altMap = altMap_ff;
        if (wrPend_ff) begin
            unique case (wrAddr_ff)
                `RPR_OFS_CAP_ROUTE: begin
                    nxt_cap8 = hwdata[`RPR_HI_LSB +: 6];
                    nxt_cap7 = hwdata[`RPR_LO_LSB +: 6];
                end
                `RPR_OFS_FAULT_ROUTE: begin
                    nxt_fltB = hwdata[`RPR_HI_LSB +: 6];
                    nxt_fltA = hwdata[`RPR_LO_LSB +: 6];
                end
                `RPR_OFS_OUT_28_29: begin
                    nxt_out29 = hwdata[`RPR_HI_LSB +: 6];
                    nxt_out28 = hwdata[`RPR_LO_LSB +: 6];
                end
                `RPR_OFS_OUT_30_31: begin
                    nxt_out31 = PIN31_PRESENT ? hwdata[`RPR_HI_LSB +: 6] : `RPR_SEL_NULL;
                    nxt_out30 = hwdata[`RPR_LO_LSB +: 6];
                end
                `RPR_OFS_ALT_CLK: begin
                    nxt_altMap = hwdata[`RPR_ALT_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // read data from next-state values, so a read right after a write sees it
    always_comb begin
        nxt_hrdata = 32'h0000_0000;
        if (addrTaken && !hwrite) begin
            unique case (haddr[7:0])
                `RPR_OFS_CAP_ROUTE:   nxt_hrdata[15:0] = pack_pair(nxt_cap8, nxt_cap7);
                `RPR_OFS_FAULT_ROUTE: nxt_hrdata[15:0] = pack_pair(nxt_fltB, nxt_fltA);
                `RPR_OFS_OUT_28_29:   nxt_hrdata[15:0] = pack_pair(nxt_out29, nxt_out28);
                `RPR_OFS_OUT_30_31:   nxt_hrdata[15:0] = pack_pair(nxt_out31, nxt_out30);
                `RPR_OFS_ALT_CLK:     nxt_hrdata[`RPR_ALT_BIT] = nxt_altMap;
                default:              nxt_hrdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wrPend_ff <= 1'b0;
            wrAddr_ff <= 8'h00;
            hrdata_ff <= 32'h0000_0000;
            cap7_ff   <= `RPR_IN_SEL_RST;
            cap8_ff   <= `RPR_IN_SEL_RST;
            fltA_ff   <= `RPR_IN_SEL_RST;
            fltB_ff   <= `RPR_IN_SEL_RST;
            out28_ff  <= `RPR_OUT_SEL_RST;
            out29_ff  <= `RPR_OUT_SEL_RST;
            out30_ff  <= `RPR_OUT_SEL_RST;
            out31_ff  <= `RPR_OUT_SEL_RST;
            altMap_ff <= `RPR_ALT_RST;
        end else begin
            wrPend_ff <= nxt_wrPend;
            wrAddr_ff <= nxt_wrAddr;
            hrdata_ff <= nxt_hrdata;
            cap7_ff   <= nxt_cap7;
            cap8_ff   <= nxt_cap8;
            fltA_ff   <= nxt_fltA;
            fltB_ff   <= nxt_fltB;
            out28_ff  <= nxt_out28;
            out29_ff  <= nxt_out29;
            out30_ff  <= nxt_out30;
            out31_ff  <= nxt_out31;
            altMap_ff <= nxt_altMap;
        end
    end

    assign hrdata    = hrdata_ff;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // input routing: two flops first, pins are asynchronous to ref_clk
    always_comb begin
        nxt_cap7In = pick_pin(cap7_ff, pinSync_ff, analogEn);
        nxt_cap8In = pick_pin(cap8_ff, pinSync_ff, analogEn);
        nxt_fltAIn = pick_pin(fltA_ff, pinSync_ff, analogEn);
        nxt_fltBIn = pick_pin(fltB_ff, pinSync_ff, analogEn);
        nxt_altClk = altMap_ff && periphOut[`RPR_SCK1_CODE];
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pinMeta_ff <= 46'h0;
            pinSync_ff <= 46'h0;
            cap7In_ff  <= 1'b0;
            cap8In_ff  <= 1'b0;
            fltAIn_ff  <= 1'b0;
            fltBIn_ff  <= 1'b0;
            altClk_ff  <= 1'b0;
        end else begin
            pinMeta_ff <= pinIn;
            pinSync_ff <= pinMeta_ff;
            cap7In_ff  <= nxt_cap7In;
            cap8In_ff  <= nxt_cap8In;
            fltAIn_ff  <= nxt_fltAIn;
            fltBIn_ff  <= nxt_fltBIn;
            altClk_ff  <= nxt_altClk;
        end
    end

    assign capCh7In  = cap7In_ff;
    assign capCh8In  = cap8In_ff;
    assign faultAIn  = fltAIn_ff;
    assign faultBIn  = fltBIn_ff;
    assign altClkOut = altClk_ff;
    // limitation: the fixed clock pin is driven the whole time the bit is set
    assign altClkOe  = altMap_ff;

    assign outSel[0] = out28_ff;
    assign outSel[1] = out29_ff;
    assign outSel[2] = out30_ff;
    assign outSel[3] = out31_ff;

    // with the bit clear the serial clock code routes like any other code
    for (genvar k = 0; k < 4; k++) begin : g_pin
        rpr_out_mux u_mux (
            .ref_clk   (ref_clk),
            .rst       (rst),
            .sel       (outSel[k]),
            .periphOut (periphOut),
            .altMapOn  (altMap_ff),
            .portOut   (portOut[k]),
            .portOe    (portOe[k]),
            .pmpOut    (pmpOut[k]),
            .pmpOe     (pmpOe[k]),
            .pinOut    (pinOut[k]),
            .pinOe     (pinOe[k])
        );
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_null_pin_free: assert property ((out28_ff == `RPR_SEL_NULL) |=>
        (pinOe[0] == $past(pmpOe[0] | portOe[0]))) else $error("null code drove pin 28");
    a_remap_drives: assert property ((out29_ff != `RPR_SEL_NULL && !(altMap_ff && out29_ff == `RPR_SCK1_CODE))
        |=> pinOe[1] && (pinOut[1] == $past(periphOut[out29_ff]))) else $error("pin 29 not remapped");
    // enable follows the bit itself, the level lags it by the output flop
    a_alt_clk_path: assert property (altMap_ff |-> altClkOe ##1
        (altClkOut == $past(periphOut[`RPR_SCK1_CODE]))) else $error("fixed clock pin wrong");
    a_sck_blocked: assert property ((altMap_ff && out30_ff == `RPR_SCK1_CODE) |=>
        (pinOe[2] == $past(pmpOe[2] | portOe[2]))) else $error("serial clock leaked to pin 30");
    a_alt_idle: assert property (!altMap_ff |-> !altClkOe ##1 !altClkOut) else $error("fixed pin active");
    a_pin31_absent: assert property (!PIN31_PRESENT |-> out31_ff == `RPR_SEL_NULL) else $error("pin 31 set");
    a_rsvd_zero: assert property (hrdata[31:14] == 18'h0 && hrdata[7:6] == 2'h0) else $error("reserved bits");
    a_cap_write: assert property (wrPend_ff && wrAddr_ff == `RPR_OFS_CAP_ROUTE |=>
        cap8_ff == $past(hwdata[13:8]) && cap7_ff == $past(hwdata[5:0])) else $error("capture write lost");
    a_analog_kill: assert property ((fltA_ff < `RPR_NUM_PINS) && analogEn[fltA_ff] |=> !faultAIn)
        else $error("analog pin fed fault A");
    a_fault_write: assert property (wrPend_ff && wrAddr_ff == `RPR_OFS_FAULT_ROUTE |=>
        fltB_ff == $past(hwdata[13:8]) && fltA_ff == $past(hwdata[5:0])) else $error("fault write lost");
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not okay");
    a_reset_vals: assert property ($fell(rst) |-> cap7_ff == `RPR_IN_SEL_RST && out28_ff == `RPR_OUT_SEL_RST
        && !altMap_ff) else $error("bad reset value");

    c_alt_on: cover property ($rose(altMap_ff));
    c_pin_remap: cover property (pinOe[0] && out28_ff != `RPR_SEL_NULL);
    c_cap_high: cover property (capCh7In);
    c_readback: cover property (addrTaken && !hwrite ##1 hrdata != 32'h0);
endmodule // rpr_router

// ---- sim/rpr_far_model.sv ----
module rpr_far_model (
    input  wire logic        ref_clk,
    input  wire logic        funcLvl,
    input  wire logic        pinLvl,
    output logic      [63:0] periphOut,
    output logic      [45:0] pinIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // odd codes and odd pins carry the inverse level, so a wrong index
    // shows as a wrong value instead of a lucky match
    always_ff @(posedge ref_clk) begin
        for (int n = 0; n < 64; n++) periphOut[n] <= funcLvl ^ n[0];
        for (int n = 0; n < 46; n++) pinIn[n] <= pinLvl ^ n[0];
    end
endmodule // rpr_far_model

// ---- sim/rpr_router_tb.sv ----
`include "rpr_defs.svh"
module rpr_router_tb
    import rpr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(got, exp) begin totalChecks++; if ((got) !== (exp)) begin nErrors++; \
    $display("[ERR] %0t got %h expected %h", $time, got, exp); end end
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [45:0] analogEn = 46'h0;
    logic [3:0]  portOut = 4'h0, portOe = 4'h0, pmpOut = 4'h0, pmpOe = 4'h0;
    logic        funcLvl = 1'b0, pinLvl = 1'b0;
    logic [31:0] hrdata, rdVal;
    logic [31:0] hrdataSmall, rdSmall;
    logic        hreadyout, hresp, altClkOut, altClkOe, capCh7In, capCh8In, faultAIn, faultBIn;
    logic [3:0]  pinOut, pinOe;
    logic [63:0] periphOut;
    logic [45:0] pinIn;
    int          nErrors = 0, totalChecks = 0, cycles = 0;

    always #20 ref_clk = ~ref_clk;

    rpr_router #(.PIN31_PRESENT(1'b1)) i_dut (
        .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .periphOut(periphOut), .pinIn(pinIn), .analogEn(analogEn), .portOut(portOut),
        .portOe(portOe), .pmpOut(pmpOut), .pmpOe(pmpOe), .pinOut(pinOut), .pinOe(pinOe),
        .altClkOut(altClkOut), .altClkOe(altClkOe), .capCh7In(capCh7In), .capCh8In(capCh8In),
        .faultAIn(faultAIn), .faultBIn(faultBIn));

    // smaller package variant: pin 31 field absent, shares the bus and pins
    rpr_router #(.PIN31_PRESENT(1'b0)) i_dut_small (
        .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdataSmall), .hreadyout(),
        .hresp(), .periphOut(periphOut), .pinIn(pinIn), .analogEn(analogEn), .portOut(portOut),
        .portOe(portOe), .pmpOut(pmpOut), .pmpOe(pmpOe), .pinOut(), .pinOe(),
        .altClkOut(), .altClkOe(), .capCh7In(), .capCh8In(),
        .faultAIn(), .faultBIn());

    rpr_far_model i_far (.ref_clk(ref_clk), .funcLvl(funcLvl), .pinLvl(pinLvl), .periphOut(periphOut),
        .pinIn(pinIn));

    task automatic endOfTest();
        $display("checks %0d errors %0d", totalChecks, nErrors);
        if (nErrors == 0 && totalChecks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // entered just after a rising edge; returns at the edge ending the data phase
    task automatic busXfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {24'h0, ofs};
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        rdVal = hrdata;
        rdSmall = hrdataSmall;
    endtask

    task automatic rdChk(input logic [7:0] ofs, input logic [31:0] exp);
        busXfer(1'b0, ofs, 32'h0);
        `CHK(rdVal, exp)
    endtask

    task automatic scnReset();
        rdChk(`RPR_OFS_CAP_ROUTE, 32'h00003F3F);
        rdChk(`RPR_OFS_FAULT_ROUTE, 32'h00003F3F);
        rdChk(`RPR_OFS_OUT_28_29, 32'h00000000);
        rdChk(`RPR_OFS_OUT_30_31, 32'h00000000);
        rdChk(`RPR_OFS_ALT_CLK, 32'h00000000);
        `CHK(pinOe, 4'h0)
        `CHK(altClkOe, 1'b0)
    endtask

    task automatic scnMask();
        logic [7:0]  ofs [5] = '{`RPR_OFS_CAP_ROUTE, `RPR_OFS_FAULT_ROUTE, `RPR_OFS_OUT_28_29,
                                 `RPR_OFS_OUT_30_31, `RPR_OFS_ALT_CLK};
        logic [31:0] exp [5] = '{32'h3F3F, 32'h3F3F, 32'h3F3F, 32'h3F3F, 32'h0001};
        for (int i = 0; i < 5; i++) begin
            busXfer(1'b1, ofs[i], 32'hFFFFFFFF);
            rdChk(ofs[i], exp[i]);
            if (i == 3) `CHK(rdSmall, 32'h0000003F)
        end
        busXfer(1'b1, 8'h14, 32'hFFFFFFFF);
        rdChk(8'h14, 32'h0);
        busXfer(1'b1, `RPR_OFS_OUT_28_29, 32'h00002A15);
        rdChk(`RPR_OFS_OUT_28_29, 32'h00002A15);
    endtask

    task automatic scnOutRoute();
        busXfer(1'b1, `RPR_OFS_ALT_CLK, 32'h0);
        busXfer(1'b1, `RPR_OFS_OUT_28_29, 32'h00000005);
        busXfer(1'b1, `RPR_OFS_OUT_30_31, 32'h00000708);
        portOut <= 4'hF;
        portOe  <= 4'hF;
        pmpOe   <= 4'h3;
        for (int l = 0; l < 2; l++) begin
            funcLvl <= l[0];
            repeat (3) @(posedge ref_clk);
            `CHK(pinOut, {~l[0], l[0], 1'b0, ~l[0]})
            `CHK(pinOe, 4'hF)
            `CHK(altClkOe, 1'b0)
        end
    endtask

    task automatic scnAltClk();
        busXfer(1'b1, `RPR_OFS_OUT_30_31, 32'h00000700);
        busXfer(1'b1, `RPR_OFS_ALT_CLK, 32'h1);
        for (int l = 0; l < 2; l++) begin
            funcLvl <= l[0];
            repeat (3) @(posedge ref_clk);
            `CHK(altClkOe, 1'b1)
            `CHK(altClkOut, l[0])
            `CHK(pinOut[2], 1'b1)
        end
        // misuse: clock code on pin 30 while the bit is set must stay off the pin
        funcLvl <= 1'b0;
        busXfer(1'b1, `RPR_OFS_OUT_30_31, 32'h00000708);
        repeat (3) @(posedge ref_clk);
        `CHK(pinOut[2], 1'b1)
        busXfer(1'b1, `RPR_OFS_ALT_CLK, 32'h0);
        repeat (3) @(posedge ref_clk);
        `CHK(altClkOe, 1'b0)
        `CHK(pinOut[2], funcLvl)
    endtask

    task automatic scnInRoute();
        busXfer(1'b1, `RPR_OFS_CAP_ROUTE, 32'h00002C03);
        busXfer(1'b1, `RPR_OFS_FAULT_ROUTE, 32'h00000A2E);
        for (int l = 0; l < 2; l++) begin
            pinLvl   <= l[0];
            analogEn <= 46'h400;
            repeat (5) @(posedge ref_clk);
            `CHK(capCh7In, ~l[0])
            `CHK(capCh8In, l[0])
            `CHK(faultAIn, 1'b0)
            `CHK(faultBIn, 1'b0)
            analogEn <= 46'h0;
            repeat (5) @(posedge ref_clk);
            `CHK(faultBIn, l[0])
        end
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            nErrors++;
            endOfTest();
        end
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        scnReset();
        scnMask();
        scnOutRoute();
        scnAltClk();
        scnInRoute();
        endOfTest();
    end
endmodule // rpr_router_tb
